/* File: rtl/timer8_pkg.sv */
`default_nettype none
package timer8_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_FORCE   = 8'h04;
  localparam logic [7:0] OFF_COUNT   = 8'h08;
  localparam logic [7:0] OFF_CMP_A   = 8'h0C;
  localparam logic [7:0] OFF_CMP_B   = 8'h10;
  localparam logic [7:0] OFF_FLAGS   = 8'h14;
  localparam logic [7:0] OFF_PORT    = 8'h18;
  // Control field positions
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_COMA_LSB  = 4;
  localparam int CTRL_COMB_LSB  = 6;
  localparam int CTRL_CS_LSB    = 8;
  // Flag and port field positions
  localparam int FLAG_OVF       = 0;
  localparam int FLAG_CMP_LSB   = 1;
  localparam int PORT_DATA_LSB  = 0;
  localparam int PORT_DIR_LSB   = 2;
  localparam int PORT_STATE_LSB = 4;
  // Reset values
  localparam logic [2:0] MODE_RESET  = 3'h0;
  localparam logic [1:0] COM_RESET   = 2'h0;
  localparam logic [2:0] CS_RESET    = 3'h0;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] CMP_RESET   = 8'h00;
  // Waveform modes handled here
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_CTC    = 3'h2;
  // Compare output actions in non-PWM modes
  localparam logic [1:0] COM_OFF     = 2'h0;
  localparam logic [1:0] COM_TOGGLE  = 2'h1;
  localparam logic [1:0] COM_CLEAR   = 2'h2;
  localparam logic [1:0] COM_SET     = 2'h3;
  localparam logic [7:0] COUNT_MAX   = 8'hFF;
  localparam logic [7:0] COUNT_ZERO  = 8'h00;
  // Prescaler: divide by 1, 8, 32, 64, 128, 256, 1024
  localparam int          PRESC_W      = 10;
  localparam logic [9:0]  PRESC_M1     = 10'h000;
  localparam logic [9:0]  PRESC_M8     = 10'h007;
  localparam logic [9:0]  PRESC_M32    = 10'h01F;
  localparam logic [9:0]  PRESC_M64    = 10'h03F;
  localparam logic [9:0]  PRESC_M128   = 10'h07F;
  localparam logic [9:0]  PRESC_M256   = 10'h0FF;
  localparam logic [9:0]  PRESC_M1024  = 10'h3FF;
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

/* File: rtl/timer8_prescaler.sv */
`default_nettype none
module timer8_prescaler
  import timer8_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [2:0] clock_select,
  output logic            timer_clock_enable
);
  logic [PRESC_W-1:0] div_count;
  logic [PRESC_W-1:0] div_mask;

  // Free running so a rate change never needs a restart
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_count <= '0;
    end else begin
      div_count <= div_count + 1'b1;
    end
  end

  always_comb begin
    case (clock_select)
      3'h1:    div_mask = PRESC_M1;
      3'h2:    div_mask = PRESC_M8;
      3'h3:    div_mask = PRESC_M32;
      3'h4:    div_mask = PRESC_M64;
      3'h5:    div_mask = PRESC_M128;
      3'h6:    div_mask = PRESC_M256;
      3'h7:    div_mask = PRESC_M1024;
      default: div_mask = PRESC_M1;
    endcase
  end

  // Zero select stops the timer
  assign timer_clock_enable = (clock_select != 3'h0) && ((div_count & div_mask) == div_mask);
endmodule
`default_nettype wire

/* File: rtl/timer8_compare_normal_ctc.sv */
// Notes on behaviour
// - Count write blocks matches next timer tick
// - Output state kept across mode changes
// - Output mode not buffered; next match
// - Nonzero output mode drives pin from state
// - Direction bit still controls pin enable
// - Override depends only on output mode
// - Output mode zero leaves state alone
// - Force applies action now, non-PWM only
// - Waveform mode sets counting; output mode not
// - Normal mode counts up, wraps FF to 00
// - Normal overflow flag set reaching zero
// - Overflow only set; acknowledge clears it
// - Normal mode count writable any time
// - Clear-on-match mode clears after channel A match
// - Clear-on-match sets flag A at top
// - Toggle mode flips output every match
// - Toggle period 2 x N x (1+compare)
// - Clear-on-match overflow on MAX to zero
// - Force sets no flag, leaves counter
// - Count write beats clear or count
// - Match sets flag next tick; one clears
`default_nettype none
module timer8_compare_normal_ctc
  import timer8_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              overflow_ack,
  input  wire logic              compare_ack_a,
  input  wire logic              compare_ack_b,
  output logic                   overflow_flag,
  output logic                   compare_flag_a,
  output logic                   compare_flag_b,
  output logic                   pin_out_a,
  output logic                   pin_oe_a,
  output logic                   pin_out_b,
  output logic                   pin_oe_b
);
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic              aw_full;
  logic              w_full;
  logic [2:0]        waveform_mode_select;
  logic [1:0]        compare_output_mode_a;
  logic [1:0]        compare_output_mode_b;
  logic [2:0]        clock_select;
  logic [7:0]        timer_count;
  logic [7:0]        compare_value_a;
  logic [7:0]        compare_value_b;
  logic [1:0]        port_data;
  logic [1:0]        compare_pin_direction_bit;
  logic              count_block;
  logic              timer_clock_enable;

  wire logic aw_fire  = awvalid && awready;
  wire logic w_fire   = wvalid && wready;
  wire logic ar_fire  = arvalid && arready;
  wire logic do_write = aw_full && w_full && !bvalid;
  wire logic lane0    = w_strb_q[0];
  wire logic lane1    = w_strb_q[1];

  wire logic next_aw_full = !do_write && (aw_full || aw_fire);
  wire logic next_w_full  = !do_write && (w_full || w_fire);
  wire logic next_bvalid  = do_write || (bvalid && !bready);
  wire logic next_rvalid  = ar_fire || (rvalid && !rready);

  wire logic wr_ctrl  = do_write && (aw_addr_q == ADDR_W'(OFF_CTRL));
  wire logic wr_force = do_write && (aw_addr_q == ADDR_W'(OFF_FORCE));
  wire logic wr_count = do_write && (aw_addr_q == ADDR_W'(OFF_COUNT)) && lane0;
  wire logic wr_cmp_a = do_write && (aw_addr_q == ADDR_W'(OFF_CMP_A));
  wire logic wr_cmp_b = do_write && (aw_addr_q == ADDR_W'(OFF_CMP_B));
  wire logic wr_flags = do_write && (aw_addr_q == ADDR_W'(OFF_FLAGS));
  wire logic wr_port  = do_write && (aw_addr_q == ADDR_W'(OFF_PORT));
  wire logic wr_hit   = wr_ctrl || wr_force || (do_write && aw_addr_q == ADDR_W'(OFF_COUNT)) ||
                        wr_cmp_a || wr_cmp_b || wr_flags || wr_port;

  timer8_prescaler u_prescaler (
    .aclk               (aclk),
    .aresetn            (aresetn),
    .clock_select       (clock_select),
    .timer_clock_enable (timer_clock_enable)
  );

  // Write channel: address and data accepted in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full  <= 1'b0;
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
    end else begin
      aw_full <= next_aw_full;
      w_full  <= next_w_full;
      awready <= !next_aw_full && !next_bvalid;
      wready  <= !next_w_full && !next_bvalid;
      bvalid  <= next_bvalid;
      if (do_write) begin
        bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (aw_fire) begin
      aw_addr_q <= awaddr;
    end
    if (w_fire) begin
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end
  end

  // Counting only in normal and clear-on-match; PWM codes hold the count
  wire logic count_mode   = (waveform_mode_select == MODE_NORMAL) || (waveform_mode_select == MODE_CTC);
  wire logic tick         = timer_clock_enable && count_mode;
  wire logic non_pwm      = count_mode;
  wire logic at_max       = (timer_count == COUNT_MAX);
  wire logic eq_a         = (timer_count == compare_value_a);
  wire logic eq_b         = (timer_count == compare_value_b);
  wire logic match_a      = tick && eq_a && !count_block;
  wire logic match_b      = tick && eq_b && !count_block;
  wire logic force_a      = wr_force && lane0 && w_data_q[0] && non_pwm;
  wire logic force_b      = wr_force && lane0 && w_data_q[1] && non_pwm;
  wire logic ctc_clear    = (waveform_mode_select == MODE_CTC) && match_a;
  wire logic ovf_set      = tick && at_max && !wr_count;
  wire logic ovf_clr      = (wr_flags && lane0 && w_data_q[FLAG_OVF]) || overflow_ack;
  wire logic cfa_clr      = (wr_flags && lane0 && w_data_q[FLAG_CMP_LSB]) || compare_ack_a;
  wire logic cfb_clr      = (wr_flags && lane0 && w_data_q[FLAG_CMP_LSB+1]) || compare_ack_b;

  // Count write beats the clock; compare A is plain compare so a low value wraps first
  wire logic [7:0] next_count = wr_count  ? w_data_q[7:0] :
                                ctc_clear ? COUNT_ZERO :
                                tick      ? timer_count + 8'h01 :
                                            timer_count;

  function automatic logic apply_action(input logic [1:0] mode, input logic state);
    case (mode)
      COM_TOGGLE: apply_action = !state;
      COM_CLEAR:  apply_action = 1'b0;
      COM_SET:    apply_action = 1'b1;
      default:    apply_action = state;
    endcase
  endfunction

  wire logic [1:0] com_vec [2];
  wire logic [1:0] ch_match;
  wire logic [1:0] ch_force;
  wire logic [1:0] ch_clr;
  wire logic [1:0] compare_output_state;
  wire logic [1:0] compare_flag_chan;
  wire logic [1:0] pin_q;
  wire logic [1:0] oe_q;

  assign com_vec[0] = compare_output_mode_a;
  assign com_vec[1] = compare_output_mode_b;
  assign ch_match   = {match_b, match_a};
  assign ch_force   = {force_b, force_a};
  assign ch_clr     = {cfb_clr, cfa_clr};

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      logic oc;
      logic flag;
      logic pin;
      logic oe;
      // Output mode read live, so a new setting takes the next match
      wire logic act = ch_match[ch] || ch_force[ch];
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          oc   <= 1'b0;
          flag <= 1'b0;
          pin  <= 1'b0;
          oe   <= 1'b0;
        end else begin
          if (act) begin
            oc <= apply_action(com_vec[ch], oc);
          end
          if (ch_match[ch]) begin
            flag <= 1'b1;
          end else if (ch_clr[ch]) begin
            flag <= 1'b0;
          end
          pin <= (com_vec[ch] != COM_OFF) ? oc : port_data[ch];
          oe  <= compare_pin_direction_bit[ch];
        end
      end
      assign compare_output_state[ch] = oc;
      assign compare_flag_chan[ch]    = flag;
      assign pin_q[ch]                = pin;
      assign oe_q[ch]                 = oe;
    end
  endgenerate

  assign compare_flag_a = compare_flag_chan[0];
  assign compare_flag_b = compare_flag_chan[1];
  assign pin_out_a      = pin_q[0];
  assign pin_out_b      = pin_q[1];
  assign pin_oe_a       = oe_q[0];
  assign pin_oe_b       = oe_q[1];

  // Registers; mode writes never touch the output state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      waveform_mode_select      <= MODE_RESET;
      compare_output_mode_a     <= COM_RESET;
      compare_output_mode_b     <= COM_RESET;
      clock_select              <= CS_RESET;
      compare_value_a           <= CMP_RESET;
      compare_value_b           <= CMP_RESET;
      port_data                 <= 2'h0;
      compare_pin_direction_bit <= 2'h0;
    end else begin
      if (wr_ctrl && lane0) begin
        waveform_mode_select  <= w_data_q[CTRL_MODE_LSB +: 3];
        compare_output_mode_a <= w_data_q[CTRL_COMA_LSB +: 2];
        compare_output_mode_b <= w_data_q[CTRL_COMB_LSB +: 2];
      end
      if (wr_ctrl && lane1) begin
        clock_select <= w_data_q[CTRL_CS_LSB +: 3];
      end
      if (wr_cmp_a && lane0) begin
        compare_value_a <= w_data_q[7:0];
      end
      if (wr_cmp_b && lane0) begin
        compare_value_b <= w_data_q[7:0];
      end
      if (wr_port && lane0) begin
        port_data                 <= w_data_q[PORT_DATA_LSB +: 2];
        compare_pin_direction_bit <= w_data_q[PORT_DIR_LSB +: 2];
      end
    end
  end

  // Block holds until a prescaler enable consumes it, even in a non-counting mode or with the timer stopped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_count   <= COUNT_RESET;
      count_block   <= 1'b0;
      overflow_flag <= 1'b0;
    end else begin
      timer_count <= next_count;
      if (wr_count) begin
        count_block <= 1'b1;
      end else if (timer_clock_enable) begin
        count_block <= 1'b0;
      end
      if (ovf_set) begin
        overflow_flag <= 1'b1;
      end else if (ovf_clr) begin
        overflow_flag <= 1'b0;
      end
    end
  end

  // Read channel
  wire logic [31:0] ctrl_word  = {21'h0, clock_select, compare_output_mode_b, compare_output_mode_a,
                                  1'b0, waveform_mode_select};
  wire logic [31:0] flag_word  = {29'h0, compare_flag_b, compare_flag_a, overflow_flag};
  wire logic [31:0] port_word  = {26'h0, compare_output_state, compare_pin_direction_bit, port_data};
  wire logic        rd_hit     = (araddr == ADDR_W'(OFF_CTRL)) || (araddr == ADDR_W'(OFF_FORCE)) ||
                                 (araddr == ADDR_W'(OFF_COUNT)) || (araddr == ADDR_W'(OFF_CMP_A)) ||
                                 (araddr == ADDR_W'(OFF_CMP_B)) || (araddr == ADDR_W'(OFF_FLAGS)) ||
                                 (araddr == ADDR_W'(OFF_PORT));
  wire logic [31:0] rd_word    = (araddr == ADDR_W'(OFF_CTRL))  ? ctrl_word :
                                 (araddr == ADDR_W'(OFF_COUNT)) ? {24'h0, timer_count} :
                                 (araddr == ADDR_W'(OFF_CMP_A)) ? {24'h0, compare_value_a} :
                                 (araddr == ADDR_W'(OFF_CMP_B)) ? {24'h0, compare_value_b} :
                                 (araddr == ADDR_W'(OFF_FLAGS)) ? flag_word :
                                 (araddr == ADDR_W'(OFF_PORT))  ? port_word : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= RESP_OKAY;
    end else begin
      arready <= !next_rvalid;
      rvalid  <= next_rvalid;
      if (ar_fire) begin
        rdata <= rd_word;
        rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_count_written;
    wr_count;
  endsequence

  sequence s_blocked_tick;
    timer_clock_enable && count_mode && count_block;
  endsequence

  a_write_blocks_match: assert property (s_count_written ##1 s_blocked_tick |=>
                                         compare_flag_a == $past(compare_flag_a && !cfa_clr) &&
                                         compare_flag_b == $past(compare_flag_b && !cfb_clr))
    else $error("match seen on tick after count write");

  a_write_wins_count: assert property (wr_count |=> timer_count == $past(w_data_q[7:0]))
    else $error("count write lost");

  a_normal_wrap_ovf: assert property (tick && waveform_mode_select == MODE_NORMAL && at_max && !wr_count
                                      |=> timer_count == 8'h00 && overflow_flag)
    else $error("normal wrap or overflow wrong");

  a_ctc_clear_top: assert property (ctc_clear && !wr_count |=> timer_count == 8'h00 && compare_flag_a)
    else $error("clear-on-match did not clear");

  a_ctc_no_early_clear: assert property (tick && waveform_mode_select == MODE_CTC && !eq_a && !at_max
                                         && !wr_count |=> timer_count == $past(timer_count) + 8'h01)
    else $error("count cleared without match");

  a_toggle_on_match: assert property (match_a && !force_a && compare_output_mode_a == COM_TOGGLE
                                      |=> compare_output_state[0] != $past(compare_output_state[0]))
    else $error("toggle missed");

  a_mode_zero_holds: assert property ((match_a || force_a) && compare_output_mode_a == COM_OFF
                                      |=> $stable(compare_output_state[0]))
    else $error("state changed with output mode zero");

  a_force_no_flag: assert property (force_a && !match_a && !cfa_clr && !tick && !wr_count
                                    |=> $stable(compare_flag_a) && $stable(timer_count))
    else $error("force touched flag or count");

  a_pin_override: assert property (1'b1 |=> pin_out_a == (($past(compare_output_mode_a) != COM_OFF) ?
                                   $past(compare_output_state[0]) : $past(port_data[0])))
    else $error("pin source wrong");

  a_flag_set_wins: assert property (match_b && cfb_clr |=> compare_flag_b)
    else $error("flag clear beat set");

  a_ovf_set_wins: assert property (ovf_set && ovf_clr |=> overflow_flag ##1 (overflow_flag || $past(ovf_clr)))
    else $error("overflow clear beat set");
endmodule
`default_nettype wire

/* File: verif/pin_model.sv */
`default_nettype none
module pin_model (
  input  wire logic out_a,
  input  wire logic oe_a,
  input  wire logic out_b,
  input  wire logic oe_b,
  output logic      level_a,
  output logic      level_b
);
  timeunit 1ns;
  timeprecision 1ps;
  // Board pull-up holds a released pin high, so a stale drive value never leaks through
  assign level_a = oe_a ? out_a : 1'b1;
  assign level_b = oe_b ? out_b : 1'b1;
endmodule
`default_nettype wire

/* File: verif/tb.sv */
`default_nettype none
module tb
  import timer8_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        overflow_ack = 1'b0, compare_ack_a = 1'b0, compare_ack_b = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd_val;
  logic [1:0]  bresp, rresp, resp;
  logic        awready, wready, bvalid, arready, rvalid, overflow_flag, compare_flag_a, compare_flag_b;
  logic        pin_out_a, pin_oe_a, pin_out_b, pin_oe_b, level_a, level_b;
  int          num_errors = 0, tests_run = 0, cycles = 0;

  timer8_compare_normal_ctc timer8_compare_normal_ctc_i (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .overflow_ack(overflow_ack),
    .compare_ack_a(compare_ack_a), .compare_ack_b(compare_ack_b), .overflow_flag(overflow_flag),
    .compare_flag_a(compare_flag_a), .compare_flag_b(compare_flag_b), .pin_out_a(pin_out_a),
    .pin_oe_a(pin_oe_a), .pin_out_b(pin_out_b), .pin_oe_b(pin_oe_b));
  pin_model pin_model_i (.out_a(pin_out_a), .oe_a(pin_oe_a), .out_b(pin_out_b), .oe_b(pin_oe_b),
    .level_a(level_a), .level_b(level_b));

  always #5 aclk = ~aclk;

  // Ceiling well above the few hundred cycles the scenarios need
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  function automatic logic [31:0] ctrl(input logic [2:0] m, input logic [1:0] com, input logic [2:0] cs);
    return {21'h0, cs, 2'h0, com, 1'b0, m};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    while (!bvalid) @(posedge aclk);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    rd_val = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic t_reset();
    rd(OFF_CTRL);
    chk("ctrl reset", 32'h0, rd_val);
    rd(OFF_COUNT);
    chk("count reset", 32'h0, rd_val);
    rd(8'h40);
    chk("unmapped read resp", 32'(RESP_SLVERR), 32'(resp));
    wr(8'h40, 32'hFF);
    chk("unmapped write resp", 32'(RESP_SLVERR), 32'(resp));
  endtask

  // Preset the output state while the pin is still an input
  task automatic t_force();
    logic [1:0] com [4] = '{COM_SET, COM_CLEAR, COM_TOGGLE, COM_OFF};
    logic       exp [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    wr(OFF_CTRL, ctrl(MODE_NORMAL, COM_OFF, 3'h0));
    wr(OFF_COUNT, 32'h37);
    wr(OFF_FLAGS, 32'h7);
    for (int i = 0; i < 4; i++) begin
      wr(OFF_CTRL, ctrl(MODE_NORMAL, com[i], 3'h0));
      wr(OFF_FORCE, 32'h1);
      rd(OFF_PORT);
      chk("forced state", 32'(exp[i]), 32'(rd_val[PORT_STATE_LSB]));
    end
    chk("flag after force", 32'h0, 32'(compare_flag_a));
    rd(OFF_COUNT);
    chk("count after force", 32'h37, rd_val);
  endtask

  task automatic t_pin();
    wr(OFF_PORT, 32'h4);
    wr(OFF_CTRL, ctrl(MODE_NORMAL, COM_OFF, 3'h0));
    repeat (2) @(posedge aclk);
    chk("pin enable", 32'h1, 32'(pin_oe_a));
    chk("pin from port", 32'h0, 32'(level_a));
    wr(OFF_CTRL, ctrl(MODE_NORMAL, COM_SET, 3'h0));
    repeat (2) @(posedge aclk);
    chk("pin from state", 32'h1, 32'(level_a));
    wr(OFF_CTRL, ctrl(MODE_CTC, COM_SET, 3'h0));
    rd(OFF_PORT);
    chk("state over mode change", 32'h1, 32'(rd_val[PORT_STATE_LSB]));
    chk("override in other mode", 32'h1, 32'(level_a));
    wr(OFF_PORT, 32'h0);
    repeat (2) @(posedge aclk);
    chk("pin released", 32'h0, 32'(pin_oe_a));
  endtask

  task automatic t_block();
    wr(OFF_CTRL, ctrl(MODE_NORMAL, COM_OFF, 3'h0));
    wr(OFF_CMP_A, 32'h5);
    wr(OFF_COUNT, 32'h5);
    wr(OFF_FLAGS, 32'h7);
    wr(OFF_CTRL, ctrl(MODE_NORMAL, COM_OFF, 3'h1));
    repeat (4) @(posedge aclk);
    chk("blocked match", 32'h0, 32'(compare_flag_a));
    wr(OFF_CTRL, ctrl(MODE_NORMAL, COM_OFF, 3'h0));
    wr(OFF_COUNT, 32'h3);
    wr(OFF_CTRL, ctrl(MODE_NORMAL, COM_OFF, 3'h1));
    repeat (6) @(posedge aclk);
    chk("match flag", 32'h1, 32'(compare_flag_a));
    compare_ack_a <= 1'b1;
    @(posedge aclk);
    compare_ack_a <= 1'b0;
    @(posedge aclk);
    chk("flag serviced", 32'h0, 32'(compare_flag_a));
  endtask

  task automatic t_normal();
    wr(OFF_CTRL, ctrl(MODE_NORMAL, COM_OFF, 3'h0));
    wr(OFF_COUNT, 32'hFD);
    wr(OFF_FLAGS, 32'h7);
    wr(OFF_CTRL, ctrl(MODE_NORMAL, COM_OFF, 3'h1));
    chk("overflow early", 32'h0, 32'(overflow_flag));
    repeat (6) @(posedge aclk);
    chk("overflow set", 32'h1, 32'(overflow_flag));
    rd(OFF_COUNT);
    chk("count wrapped", 32'h0, 32'(rd_val[7:4]));
    chk("overflow held", 32'h1, 32'(overflow_flag));
    overflow_ack <= 1'b1;
    @(posedge aclk);
    overflow_ack <= 1'b0;
    @(posedge aclk);
    chk("overflow serviced", 32'h0, 32'(overflow_flag));
  endtask

  task automatic t_ctc();
    int   g;
    logic p;
    wr(OFF_CTRL, ctrl(MODE_CTC, COM_OFF, 3'h0));
    wr(OFF_CMP_A, 32'h3);
    wr(OFF_COUNT, 32'h0);
    wr(OFF_FLAGS, 32'h7);
    wr(OFF_PORT, 32'h4);
    wr(OFF_CTRL, ctrl(MODE_CTC, COM_TOGGLE, 3'h1));
    g = 0;
    // Let the switch of pin source settle so only real toggles are timed
    repeat (2) @(posedge aclk);
    p = level_a;
    while (level_a === p) @(posedge aclk);
    p = level_a;
    while (level_a === p) begin
      @(posedge aclk);
      g++;
    end
    chk("toggle half period", 32'h4, 32'(g));
    chk("top flag", 32'h1, 32'(compare_flag_a));
    rd(OFF_COUNT);
    chk("count above top", 32'h0, 32'(rd_val[7:0] > 8'h3));
    chk("no overflow below max", 32'h0, 32'(overflow_flag));
  endtask

  // Channel B: forced preset, then a match and a wrap that meet a service pulse
  task automatic t_chan_b();
    wr(OFF_CTRL, ctrl(MODE_NORMAL, COM_OFF, 3'h0) | (32'(COM_SET) << CTRL_COMB_LSB));
    wr(OFF_FORCE, 32'h2);
    wr(OFF_PORT, 32'h8);
    rd(OFF_PORT);
    chk("state b forced", 32'h1, 32'(rd_val[PORT_STATE_LSB+1]));
    chk("pin b from state", 32'h1, 32'(level_b));
    wr(OFF_CMP_B, 32'hFF);
    wr(OFF_COUNT, 32'hF8);
    wr(OFF_FLAGS, 32'h7);
    wr(OFF_CTRL, ctrl(MODE_NORMAL, COM_OFF, 3'h1) | (32'(COM_CLEAR) << CTRL_COMB_LSB));
    repeat (6) @(posedge aclk);
    compare_ack_b <= 1'b1;
    overflow_ack <= 1'b1;
    @(posedge aclk);
    compare_ack_b <= 1'b0;
    overflow_ack <= 1'b0;
    @(posedge aclk);
    chk("flag b set wins", 32'h1, 32'(compare_flag_b));
    chk("overflow set wins", 32'h1, 32'(overflow_flag));
    @(posedge aclk);
    chk("pin b cleared", 32'h0, 32'(level_b));
  endtask

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_force();
    t_pin();
    t_block();
    t_normal();
    t_ctc();
    t_chan_b();
    summarize();
  end
endmodule
`default_nettype wire
